// ### logic/pbm_map.svh
// constants for the port b bus-matching, swap and parity block
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH
`define PBM_FIFO_DEPTH     7'h40
`define PBM_OFFSET_HH      7'h10
`define PBM_OFFSET_HL      7'h0C
`define PBM_OFFSET_LH      7'h08
`define PBM_OFFSET_LL      7'h04
`define PBM_SWAP_NONE      2'h0
`define PBM_SWAP_REVERSE   2'h1
`define PBM_SWAP_HALVES    2'h2
`define PBM_SWAP_PAIRS     2'h3
`define PBM_LAST_LONG      2'h0
`define PBM_LAST_WORD      2'h1
`define PBM_LAST_BYTE      2'h3
`define PBM_LANE_TOP       2'h3
`define PBM_LANE_BOTTOM    2'h0
`endif

// ### logic/pbm_pkg.sv
// types shared by the port b bus-matching block
package pbm_pkg;
  typedef enum logic [1:0] {PBM_LONG, PBM_WORD, PBM_BYTE} pbm_width_type;
endpackage

// ### logic/pbm_parity.sv
// four 9-bit parity trees: byte check and parity substitution
`timescale 1ns/1ns
module pbm_parity (
  // data and parity sense
  input  wire logic [35:0] data,
  input  wire logic        odd_select,
  // results
  output logic      [3:0]  byte_error,
  output logic      [35:0] generated
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tree
      wire logic [8:0] grp      = data[9*g +: 9];
      // odd count of lows in 9 bits means even count of ones
      wire logic       ones_odd = ^grp;
      wire logic       low8_odd = ^grp[7:0];
      assign byte_error[g]         = odd_select ? ~ones_odd : ones_odd;
      assign generated[9*g +: 9]   = {odd_select ? ~low8_odd : low8_odd, grp[7:0]};
    end
  endgenerate
endmodule

// ### logic/pbm_top.sv
// port b bus matching, byte swapping, parity and fifo2 flag levels
`timescale 1ns/1ns
`include "pbm_map.svh"
//
// What this block does
// - fifo2 flags follow stored level and offset
// - port b long, word, byte; big/little lanes
// - size and endian selects captured, used next edge
// - storage holds long words; mailboxes never converted
// - narrow fifo1 reads release aux parts in turn
// - new width on read fetches fresh word
// - unused read lanes hold last value
// - narrow writes assemble; last part commits word
// - new width on write restarts assembly
// - both sizes high selects mailboxes, full width
// - mailbox access keeps previous width selection
// - four byte orders, whole bytes, not mailbox
// - swap sampled at start of each long word
// - read swaps then narrows; write assembles then swaps
// - four byte parity checks per port, valid lanes
// - odd/even sense of low-bit count flags error
// - mailbox read with generation forces error high
// - generated parity replaces each byte top bit
// - writes store all nine bits unchanged
// - fifo1 and port a read parity generated before output register
// - mailbox parity generation only on selected read
// - transfer on edge with select low, enable high
// - big-endian uses top lanes, little bottom lanes
// - swap codes give ABCD, DCBA, CDAB, BADC
module pbm_top import pbm_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // port b control
  input  wire logic        port_b_chip_select_n,
  input  wire logic        port_b_transfer_enable,
  input  wire logic        port_b_write_not_read,
  input  wire logic        width_select_lo,
  input  wire logic        width_select_hi,
  input  wire logic        big_endian_select_n,
  input  wire logic        swap_select_lo,
  input  wire logic        swap_select_hi,
  input  wire logic        port_b_parity_generate,
  input  wire logic        odd_parity_select,
  // port b bus
  input  wire logic [35:0] port_b_data_in,
  output logic      [35:0] port_b_data_out,
  output logic             port_b_data_oe,
  output logic             port_b_parity_error_n,
  // fifo1 storage head and mail1 register
  input  wire logic [35:0] fifo1_read_data,
  output logic             fifo1_read_strobe,
  input  wire logic [35:0] mail1_data,
  output logic             mail1_read_strobe,
  // fifo2 storage and mail2 register
  output logic      [35:0] fifo2_write_data,
  output logic             fifo2_write_strobe,
  output logic      [35:0] mail2_write_data,
  output logic             mail2_write_strobe,
  // port a checking and read generation
  input  wire logic        port_a_chip_select_n,
  input  wire logic        port_a_transfer_enable,
  input  wire logic        port_a_write_not_read,
  input  wire logic        port_a_mailbox_select,
  input  wire logic        port_a_parity_generate,
  input  wire logic [35:0] port_a_data_in,
  input  wire logic [35:0] port_a_read_word,
  output logic      [35:0] port_a_data_out,
  output logic             port_a_parity_error_n,
  // fifo2 level and flags
  input  wire logic [6:0]  fifo2_level,
  input  wire logic        offset_select_lo,
  input  wire logic        offset_select_hi,
  output logic             fifo2_empty_n,
  output logic             fifo2_almost_empty_n,
  output logic             fifo2_almost_full_n,
  output logic             fifo2_full_n
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] swap_bytes(input logic [35:0] w, input logic [1:0] code);
    case (code)
      `PBM_SWAP_REVERSE: swap_bytes = {w[8:0], w[17:9], w[26:18], w[35:27]};
      `PBM_SWAP_HALVES:  swap_bytes = {w[17:9], w[8:0], w[35:27], w[26:18]};
      `PBM_SWAP_PAIRS:   swap_bytes = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default:           swap_bytes = w;
    endcase
  endfunction
  // lane enable and source byte for part k of a long word
  function automatic logic [2:0] lane_map(input pbm_width_type w, input logic big, input logic [1:0] k,
                                          input logic [1:0] lane);
    case (w)
      PBM_WORD: lane_map = big ? {lane[1], 2'(lane - {k[0], 1'b0})} : {~lane[1], 2'(lane + {k[0], 1'b0})};
      PBM_BYTE: lane_map = big ? {lane == `PBM_LANE_TOP, 2'(`PBM_LANE_TOP - k)} : {lane == `PBM_LANE_BOTTOM, k};
      default:  lane_map = {1'b1, lane};
    endcase
  endfunction

  function automatic logic [1:0] last_part(input pbm_width_type w);
    case (w)
      PBM_WORD: last_part = `PBM_LAST_WORD;
      PBM_BYTE: last_part = `PBM_LAST_BYTE;
      default:  last_part = `PBM_LAST_LONG;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // captured selections
  pbm_width_type width_reg;
  logic          mbx_reg;
  logic          big_reg;
  logic [6:0]    offset_reg;
  wire logic     sel_mbx   = width_select_hi & width_select_lo;
  wire pbm_width_type width_in = width_select_hi ? PBM_WORD : (width_select_lo ? PBM_BYTE : PBM_LONG);
  wire logic [2:0] key_now = {width_reg, big_reg};
  wire logic [1:0] swap_in = {swap_select_hi, swap_select_lo};
  wire logic [1:0] last_now = last_part(width_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      width_reg <= PBM_LONG;
      mbx_reg   <= 1'b0;
      big_reg   <= 1'b0;
    end else begin
      mbx_reg <= sel_mbx;
      big_reg <= ~big_endian_select_n;
      if (!sel_mbx)
        width_reg <= width_in;
    end
  end

  // offset is caught while reset is held; sync reset so a pin value is legal here
  always_ff @(posedge mclk) begin
    if (rst)
      case ({offset_select_hi, offset_select_lo})
        2'h3:    offset_reg <= `PBM_OFFSET_HH;
        2'h2:    offset_reg <= `PBM_OFFSET_HL;
        2'h1:    offset_reg <= `PBM_OFFSET_LH;
        default: offset_reg <= `PBM_OFFSET_LL;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer decode
  wire logic b_sel     = ~port_b_chip_select_n & port_b_transfer_enable;
  wire logic b_rd_fifo = b_sel & ~port_b_write_not_read & ~mbx_reg;
  wire logic b_wr_fifo = b_sel & port_b_write_not_read & ~mbx_reg;
  wire logic b_rd_mbx  = b_sel & ~port_b_write_not_read & mbx_reg;
  wire logic b_wr_mbx  = b_sel & port_b_write_not_read & mbx_reg;
  wire logic b_mb_gen  = b_rd_mbx & port_b_parity_generate;
  wire logic a_rd      = ~port_a_chip_select_n & port_a_transfer_enable & ~port_a_write_not_read;
  wire logic a_mb_gen  = a_rd & port_a_mailbox_select & port_a_parity_generate;

  ////////////////////////////////////////////////////////////////////////////
  // parity trees
  logic [3:0]  a_err;
  logic [3:0]  b_err;
  logic [35:0] f1_gen;
  logic [35:0] m1_gen;
  logic [35:0] a_gen;
  logic [35:0] f1_swapped;
  assign f1_swapped = swap_bytes(fifo1_read_data, swap_in);

  pbm_parity u_chk_a (.data(port_a_data_in), .odd_select(odd_parity_select), .byte_error(a_err), .generated());
  pbm_parity u_chk_b (.data(port_b_data_in), .odd_select(odd_parity_select), .byte_error(b_err), .generated());
  pbm_parity u_gen_f1 (.data(f1_swapped), .odd_select(odd_parity_select), .byte_error(), .generated(f1_gen));
  pbm_parity u_gen_m1 (.data(mail1_data), .odd_select(odd_parity_select), .byte_error(), .generated(m1_gen));
  pbm_parity u_gen_a (.data(port_a_read_word), .odd_select(odd_parity_select), .byte_error(), .generated(a_gen));

  logic [3:0] b_valid;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_valid
      wire logic [2:0] vmap = lane_map(width_reg, big_reg, 2'h0, 2'(gl));
      assign b_valid[gl] = mbx_reg | vmap[2];
    end
  endgenerate

  logic pe_a_reg;
  logic pe_b_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      pe_a_reg <= 1'b1;
      pe_b_reg <= 1'b1;
    end else begin
      pe_a_reg <= a_mb_gen | ~|a_err;
      pe_b_reg <= b_mb_gen | ~|(b_err & b_valid);
    end
  end
  assign port_a_parity_error_n = pe_a_reg;
  assign port_b_parity_error_n = pe_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // fifo1 read path: swap, generate, then narrow
  logic [35:0] rd_aux_reg;
  logic [35:0] rd_out_reg;
  logic [1:0]  rd_idx_reg;
  logic        rd_more_reg;
  logic [2:0]  rd_key_reg;
  wire logic   rd_new  = ~rd_more_reg | (rd_key_reg != key_now);
  wire logic [1:0]  rd_k    = rd_new ? 2'h0 : 2'(rd_idx_reg + 2'h1);
  wire logic [35:0] rd_src  = rd_new ? (port_b_parity_generate ? f1_gen : f1_swapped) : rd_aux_reg;
  logic [35:0] rd_out_next;
  logic [35:0] wr_asm_next;
  logic [35:0] wr_asm_reg;

  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      wire logic [2:0] rmap = lane_map(width_reg, big_reg, rd_k, 2'(gl));
      assign rd_out_next[9*gl +: 9] = rmap[2] ? rd_src[9*rmap[1:0] +: 9] : rd_out_reg[9*gl +: 9];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_aux_reg  <= 36'h0;
      rd_out_reg  <= 36'h0;
      rd_idx_reg  <= 2'h0;
      rd_more_reg <= 1'b0;
      rd_key_reg  <= 3'h0;
    end else if (b_rd_fifo) begin
      rd_out_reg  <= rd_out_next;
      rd_aux_reg  <= rd_src;
      rd_idx_reg  <= rd_k;
      rd_more_reg <= rd_k != last_now;
      rd_key_reg  <= key_now;
    end
  end
  assign fifo1_read_strobe = b_rd_fifo & rd_new;

  // mail1 bypasses narrowing and swapping
  assign port_b_data_out   = mbx_reg ? (b_mb_gen ? m1_gen : mail1_data) : rd_out_reg;
  assign port_b_data_oe    = ~port_b_chip_select_n & ~port_b_write_not_read;
  assign mail1_read_strobe = b_rd_mbx;

  ////////////////////////////////////////////////////////////////////////////
  // fifo2 write path: assemble, then swap on commit
  logic [1:0]  wr_idx_reg;
  logic        wr_more_reg;
  logic [2:0]  wr_key_reg;
  logic [1:0]  wr_swap_reg;
  logic [35:0] f2_data_reg;
  logic        f2_strobe_reg;
  logic [35:0] m2_data_reg;
  logic        m2_strobe_reg;
  wire logic   wr_new  = ~wr_more_reg | (wr_key_reg != key_now);
  wire logic [1:0] wr_k    = wr_new ? 2'h0 : 2'(wr_idx_reg + 2'h1);
  wire logic [1:0] wr_swap = wr_new ? swap_in : wr_swap_reg;
  wire logic   wr_done = wr_k == last_now;

  generate
    for (gl = 0; gl < 4; gl++) begin : g_asm
      wire logic [2:0] m0 = lane_map(width_reg, big_reg, wr_k, 2'h0);
      wire logic [2:0] m1 = lane_map(width_reg, big_reg, wr_k, 2'h1);
      wire logic [2:0] m2 = lane_map(width_reg, big_reg, wr_k, 2'h2);
      wire logic [2:0] m3 = lane_map(width_reg, big_reg, wr_k, 2'h3);
      assign wr_asm_next[9*gl +: 9] =
        (m3[2] && m3[1:0] == 2'(gl)) ? port_b_data_in[35:27] :
        (m2[2] && m2[1:0] == 2'(gl)) ? port_b_data_in[26:18] :
        (m1[2] && m1[1:0] == 2'(gl)) ? port_b_data_in[17:9]  :
        (m0[2] && m0[1:0] == 2'(gl)) ? port_b_data_in[8:0]   : wr_asm_reg[9*gl +: 9];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_asm_reg    <= 36'h0;
      wr_idx_reg    <= 2'h0;
      wr_more_reg   <= 1'b0;
      wr_key_reg    <= 3'h0;
      wr_swap_reg   <= `PBM_SWAP_NONE;
      f2_data_reg   <= 36'h0;
      f2_strobe_reg <= 1'b0;
      m2_data_reg   <= 36'h0;
      m2_strobe_reg <= 1'b0;
    end else begin
      f2_strobe_reg <= b_wr_fifo & wr_done;
      m2_strobe_reg <= b_wr_mbx;
      if (b_wr_mbx)
        m2_data_reg <= port_b_data_in;
      if (b_wr_fifo) begin
        wr_asm_reg  <= wr_asm_next;
        wr_idx_reg  <= wr_k;
        wr_more_reg <= ~wr_done;
        wr_key_reg  <= key_now;
        wr_swap_reg <= wr_swap;
        if (wr_done)
          f2_data_reg <= swap_bytes(wr_asm_next, wr_swap);
      end
    end
  end
  assign fifo2_write_data   = f2_data_reg;
  assign fifo2_write_strobe = f2_strobe_reg;
  assign mail2_write_data   = m2_data_reg;
  assign mail2_write_strobe = m2_strobe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // port a read output and fifo2 flags
  logic [35:0] a_out_reg;
  logic [3:0]  flag_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_out_reg <= 36'h0;
      flag_reg  <= 4'h0;
    end else begin
      if (a_rd)
        a_out_reg <= port_a_parity_generate ? a_gen : port_a_read_word;
      flag_reg <= {fifo2_level != 7'h0, fifo2_level > offset_reg,
                   fifo2_level < 7'(`PBM_FIFO_DEPTH - offset_reg), fifo2_level != `PBM_FIFO_DEPTH};
    end
  end
  assign port_a_data_out      = a_out_reg;
  assign fifo2_empty_n        = flag_reg[3];
  assign fifo2_almost_empty_n = flag_reg[2];
  assign fifo2_almost_full_n  = flag_reg[1];
  assign fifo2_full_n         = flag_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  sequence s_long_write;
    b_wr_fifo && width_reg == PBM_LONG;
  endsequence
  sequence s_byte_follow;
    b_rd_fifo && width_reg == PBM_BYTE && !rd_new;
  endsequence

  property p_full_flag;
    @(posedge mclk) disable iff (rst) fifo2_level == `PBM_FIFO_DEPTH |=> !fifo2_full_n && !fifo2_almost_full_n;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flags not low at depth");
  property p_empty_flag;
    @(posedge mclk) disable iff (rst) fifo2_level == 7'h0 |=> !fifo2_empty_n && !fifo2_almost_empty_n;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flags not low at zero");
  property p_capture;
    @(posedge mclk) disable iff (rst) ##1 mbx_reg == $past(sel_mbx);
  endproperty
  a_capture: assert property (p_capture) else $error("mailbox selection not captured");
  property p_long_commit;
    @(posedge mclk) disable iff (rst) s_long_write |=> fifo2_write_strobe;
  endproperty
  a_long_commit: assert property (p_long_commit) else $error("long write not committed");
  property p_reverse;
    @(posedge mclk) disable iff (rst) s_long_write and swap_in == `PBM_SWAP_REVERSE
      |=> fifo2_write_data[35:27] == $past(port_b_data_in[8:0]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse swap wrong on write");
  property p_byte_hold;
    @(posedge mclk) disable iff (rst) s_byte_follow |-> !fifo1_read_strobe;
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte read fetched early");
  property p_static_lanes;
    @(posedge mclk) disable iff (rst) b_rd_fifo && width_reg == PBM_BYTE && big_reg
      |=> $stable(rd_out_reg[26:0]);
  endproperty
  a_static_lanes: assert property (p_static_lanes) else $error("unused lanes changed");
  property p_mbx_write;
    @(posedge mclk) disable iff (rst) b_wr_mbx |=> mail2_write_strobe && !fifo2_write_strobe;
  endproperty
  a_mbx_write: assert property (p_mbx_write) else $error("mailbox write disturbed fifo2");
  property p_pe_forced;
    @(posedge mclk) disable iff (rst) b_mb_gen |=> port_b_parity_error_n;
  endproperty
  a_pe_forced: assert property (p_pe_forced) else $error("parity error not forced high");
  property p_keep_width;
    @(posedge mclk) disable iff (rst) sel_mbx |=> width_reg == $past(width_reg);
  endproperty
  a_keep_width: assert property (p_keep_width) else $error("width lost on mailbox access");
endmodule

// ### verification/pbm_store_model.sv
// fifo1 head, mail1, fifo2 storage and mail2 stand-in for the bench
`timescale 1ns/1ns
module pbm_store_model (
  // clock
  input  wire logic        mclk,
  // fifo1 and mail1 side
  input  wire logic        fifo1_read_strobe,
  input  wire logic        mail1_read_strobe,
  output logic      [35:0] fifo1_read_data,
  output logic      [35:0] mail1_data,
  // fifo2 and mail2 side
  input  wire logic        fifo2_write_strobe,
  input  wire logic [35:0] fifo2_write_data,
  input  wire logic        mail2_write_strobe,
  input  wire logic [35:0] mail2_write_data
);
  int          pops = 0;
  int          mail_reads = 0;
  logic [35:0] f2_q[$];
  logic [35:0] mail2_reg = 36'h0;
  // head word changes only after a pop, so a fetch always sees one stable word
  assign fifo1_read_data = {9'h1A1, 9'h0B2, 9'h1C3, 9'h0D4} ^ {4{pops[8:0]}};
  assign mail1_data = 36'h987654321;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (fifo1_read_strobe) begin
      pops <= pops + 1;
    end
    if (mail1_read_strobe) begin
      mail_reads <= mail_reads + 1;
    end
    // storage takes whole long words only
    if (fifo2_write_strobe) begin
      f2_q.push_back(fifo2_write_data);
    end
    if (mail2_write_strobe) begin
      mail2_reg <= mail2_write_data;
    end
  end
endmodule

// ### verification/pbm_top_tb.sv
// self-checking bench for the port b bus-matching block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module pbm_top_tb;
  int          n_errors = 0;
  int          total_checks = 0;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic        port_b_chip_select_n = 1'h1, port_b_transfer_enable = 1'h0, port_b_write_not_read = 1'h0;
  logic        width_select_lo = 1'h0, width_select_hi = 1'h0, big_endian_select_n = 1'h1;
  logic        swap_select_lo = 1'h0, swap_select_hi = 1'h0, port_b_parity_generate = 1'h0, odd_parity_select = 1'h1;
  logic        port_a_chip_select_n = 1'h1, port_a_transfer_enable = 1'h0, port_a_write_not_read = 1'h0;
  logic        port_a_mailbox_select = 1'h0, port_a_parity_generate = 1'h0;
  logic        offset_select_lo = 1'h0, offset_select_hi = 1'h0;
  logic [35:0] port_b_data_in = 36'h0, port_a_data_in = 36'h0, port_a_read_word = 36'h0;
  logic [6:0]  fifo2_level = 7'h0;
  logic [35:0] port_b_data_out, fifo1_read_data, mail1_data, fifo2_write_data, mail2_write_data, port_a_data_out;
  logic        port_b_data_oe, port_b_parity_error_n, fifo1_read_strobe, mail1_read_strobe, fifo2_write_strobe;
  logic        mail2_write_strobe, port_a_parity_error_n;
  logic        fifo2_empty_n, fifo2_almost_empty_n, fifo2_almost_full_n, fifo2_full_n;
  logic [35:0] s, p, q;

  always #50 mclk = ~mclk;

  pbm_top dut_u (.mclk, .rst, .port_b_chip_select_n, .port_b_transfer_enable, .port_b_write_not_read,
    .width_select_lo, .width_select_hi, .big_endian_select_n, .swap_select_lo, .swap_select_hi,
    .port_b_parity_generate, .odd_parity_select, .port_b_data_in, .port_b_data_out, .port_b_data_oe,
    .port_b_parity_error_n, .fifo1_read_data, .fifo1_read_strobe, .mail1_data, .mail1_read_strobe,
    .fifo2_write_data, .fifo2_write_strobe, .mail2_write_data, .mail2_write_strobe, .port_a_chip_select_n,
    .port_a_transfer_enable, .port_a_write_not_read, .port_a_mailbox_select, .port_a_parity_generate,
    .port_a_data_in, .port_a_read_word, .port_a_data_out, .port_a_parity_error_n, .fifo2_level,
    .offset_select_lo, .offset_select_hi, .fifo2_empty_n, .fifo2_almost_empty_n, .fifo2_almost_full_n,
    .fifo2_full_n);

  pbm_store_model store_u (.mclk, .fifo1_read_strobe, .mail1_read_strobe, .fifo1_read_data, .mail1_data,
    .fifo2_write_strobe, .fifo2_write_data, .mail2_write_strobe, .mail2_write_data);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] w1(input int k);
    return {9'h1A1, 9'h0B2, 9'h1C3, 9'h0D4} ^ {4{k[8:0]}};
  endfunction

  function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] c);
    case (c)
      2'h0: return w;
      2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: return {w[17:9], w[8:0], w[35:27], w[26:18]};
      default: return {w[26:18], w[35:27], w[8:0], w[17:9]};
    endcase
  endfunction

  function automatic logic [35:0] gen(input logic [35:0] w, input logic o);
    logic [35:0] r;
    r = w;
    for (int i = 0; i < 4; i++) begin
      r[9 * i + 8] = o ? ~^w[9 * i +: 8] : ^w[9 * i +: 8];
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // size goes out one edge ahead of the transfer because the block uses last edge's selection
  task automatic xb(input logic [2:0] sz, input logic [1:0] sw, input logic wnr, input logic [35:0] d);
    @(posedge mclk);
    {width_select_hi, width_select_lo, big_endian_select_n} <= sz;
    {swap_select_hi, swap_select_lo} <= sw;
    @(posedge mclk);
    port_b_chip_select_n <= 1'h0;
    port_b_transfer_enable <= 1'h1;
    port_b_write_not_read <= wnr;
    port_b_data_in <= d;
    // taken mid-cycle while the request stands: mailbox parity generation ends with enable
    @(negedge mclk) q = port_b_data_out;
    @(posedge mclk);
    port_b_transfer_enable <= 1'h0;
    port_b_data_in <= ~d;
    #1;
  endtask

  task automatic pg(input logic v);
    @(posedge mclk) port_b_parity_generate <= v;
  endtask

  task automatic pa(input logic m);
    @(posedge mclk);
    port_a_chip_select_n <= 1'h0;
    port_a_transfer_enable <= 1'h1;
    port_a_mailbox_select <= m;
    port_a_parity_generate <= 1'h1;
    port_a_data_in <= {4{9'h001}};
    port_a_read_word <= 36'h13579BDF0;
    @(posedge mclk);
    port_a_transfer_enable <= 1'h0;
    #1;
  endtask

  task automatic flags(input int x);
    int lv[8];
    lv = '{0, 1, x, x + 1, 63 - x, 64 - x, 63, 64};
    foreach (lv[i]) begin
      @(posedge mclk) fifo2_level <= lv[i][6:0];
      @(posedge mclk) #1;
      `CHK(fifo2_empty_n, lv[i] != 0)
      `CHK(fifo2_almost_empty_n, lv[i] > x)
      `CHK(fifo2_almost_full_n, lv[i] < 64 - x)
      `CHK(fifo2_full_n, lv[i] != 64)
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk) #1;
    // all-zero bytes hold nine lows, an odd count, so odd parity flags them
    `CHK(port_b_parity_error_n, 1'h0)
    flags(4);
    for (int i = 0; i < 4; i++) begin
      xb(3'h1, i[1:0], 1'h0, 36'h0);
      `CHK(port_b_data_out, swp(w1(i), i[1:0]))
    end
    `CHK(port_b_data_oe, 1'h1)
    pg(1'h1);
    xb(3'h1, 2'h0, 1'h0, 36'h0);
    p = gen(w1(4), 1'h1);
    `CHK(port_b_data_out, p)
    pg(1'h0);
    s = swp(w1(5), 2'h1);
    xb(3'h2, 2'h1, 1'h0, 36'h0);
    `CHK(port_b_data_out, {s[35:27], p[26:0]})
    pg(1'h1);
    xb(3'h6, 2'h2, 1'h0, 36'h0);
    `CHK(q, gen(36'h987654321, 1'h1))
    `CHK(port_b_parity_error_n, 1'h1)
    `CHK(store_u.mail_reads, 1)
    pg(1'h0);
    // swap code changes mid-word and must be ignored
    for (int j = 2; j >= 0; j--) begin
      xb(3'h2, 2'h3, 1'h0, 36'h0);
      `CHK(port_b_data_out[35:27], s[9 * j +: 9])
    end
    `CHK(store_u.pops, 6)
    s = w1(6);
    xb(3'h4, 2'h0, 1'h0, 36'h0);
    `CHK(port_b_data_out[35:18], s[35:18])
    xb(3'h1, 2'h0, 1'h0, 36'h0);
    `CHK(port_b_data_out, w1(7))
    `CHK(store_u.pops, 8)
    s = w1(8);
    for (int j = 0; j < 4; j++) begin
      xb(3'h3, 2'h0, 1'h0, 36'h0);
      `CHK(port_b_data_out[8:0], s[9 * j +: 9])
    end
    // half a word is abandoned by the width change that follows
    xb(3'h5, 2'h0, 1'h1, 36'h123456789);
    xb(3'h1, 2'h1, 1'h1, {9'h001, 9'h007, 9'h1FF, 9'h10F});
    `CHK(port_b_parity_error_n, 1'h1)
    `CHK(port_b_data_oe, 1'h0)
    `CHK(fifo2_write_strobe, 1'h1)
    `CHK(fifo2_write_data, swp({9'h001, 9'h007, 9'h1FF, 9'h10F}, 2'h1))
    xb(3'h5, 2'h2, 1'h1, {18'h0, 18'h00F0F});
    `CHK(port_b_parity_error_n, 1'h1)
    xb(3'h7, 2'h2, 1'h1, 36'h0FEDCBA98);
    `CHK(mail2_write_strobe, 1'h1)
    `CHK(mail2_write_data, 36'h0FEDCBA98)
    xb(3'h5, 2'h1, 1'h1, {18'h3FFFF, 18'h2468A});
    `CHK(fifo2_write_data, swp({18'h2468A, 18'h00F0F}, 2'h2))
    // storage takes the word on the edge after the strobe
    @(posedge mclk) #1;
    `CHK(store_u.f2_q.size(), 2)
    for (int j = 0; j < 4; j++) begin
      xb(3'h2, j == 0 ? 2'h3 : 2'h1, 1'h1, {9'(j + 9'h0A0), 27'h0});
    end
    `CHK(fifo2_write_data, swp({9'h0A0, 9'h0A1, 9'h0A2, 9'h0A3}, 2'h3))
    @(posedge mclk) odd_parity_select <= 1'h0;
    pa(1'h0);
    `CHK(port_a_data_out, gen(36'h13579BDF0, 1'h0))
    `CHK(port_a_parity_error_n, 1'h0)
    pa(1'h1);
    `CHK(port_a_parity_error_n, 1'h1)
    @(posedge mclk) begin
      rst <= 1'h1;
      offset_select_lo <= 1'h1;
      offset_select_hi <= 1'h1;
    end
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    flags(16);
    complete_run();
  end
endmodule
